/* verilog/iex_core.sv */
// Execute stage that applies one instruction per request to registers, memory and flags.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`default_nettype none
module iex_core #(
  parameter int unsigned PRECLEAR_PAIRED = 1
) (
  input  wire logic                           I_CLOCK,
  input  wire logic                           I_RESET,
  input  wire logic                           I_EXEC,
  input  wire logic [iex_pkg::OP_W-1:0]       I_OPCODE,
  input  wire logic [iex_pkg::ADDR_W-1:0]     I_MEM_ADDR,
  input  wire logic [iex_pkg::DATA_W-1:0]     I_MEM_RDATA,
  input  wire logic [iex_pkg::DATA_W-1:0]     I_IMMEDIATE,
  input  wire logic [iex_pkg::PC_W-1:0]       I_TARGET,
  input  wire logic [2:0]                     I_BIT_SEL,
  input  wire logic                           I_WAKE,
  input  wire logic                           I_WD_EXPIRE,
  output logic [iex_pkg::PC_W-1:0]            O_PC,
  output logic [iex_pkg::DATA_W-1:0]          O_WORK_REG,
  output logic                                O_MEM_WE,
  output logic [iex_pkg::ADDR_W-1:0]          O_MEM_WADDR,
  output logic [iex_pkg::DATA_W-1:0]          O_MEM_WDATA,
  output logic                                O_ZERO,
  output logic                                O_CARRY,
  output logic                                O_HALF_SPILL_BIT,
  output logic                                O_SIGNED_RANGE_FAULT_BIT,
  output logic                                O_WATCHDOG_EXPIRY_BIT,
  output logic                                O_POWERDOWN_BIT,
  output logic                                O_WATCHDOG_CLEAR,
  output logic                                O_CLOCK_RUN,
  output logic [iex_pkg::SP_W-1:0]            O_STACK_PTR
);

  typedef struct packed {
    logic [iex_pkg::PC_W-1:0]   pc;
    logic [iex_pkg::DATA_W-1:0] acc;
    logic                       mem_we;
    logic [iex_pkg::ADDR_W-1:0] mem_waddr;
    logic [iex_pkg::DATA_W-1:0] mem_wdata;
    logic                       zero;
    logic                       carry;
    logic                       half;
    logic                       ovf;
    logic                       expiry;
    logic                       pdown;
    logic                       wd_clear;
    logic                       asleep;
    logic                       run;
    logic                       pre1_seen;
    logic                       pre2_seen;
    logic [iex_pkg::SP_W-1:0]   sp;
  } iex_state_s;

  iex_state_s state_reg;
  iex_state_s state_next;
  logic [iex_pkg::PC_W-1:0] stack_mem [iex_pkg::STACK_D];

  // Nine-bit sum with nibble carry and signed overflow, shared by all add forms.
  function automatic logic [11:0] iex_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    logic       ov;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    ov   = (a[7] == b[7]) && (full[7] != a[7]);
    return {ov, lo[4], full[8], full[7:0], 1'b0};
  endfunction : iex_add

  logic [11:0] sum_w;
  logic [4:0]  fix_lo;
  logic [8:0]  fix_hi;
  logic        fix_lo_c;
  logic [7:0]  mem_bit_cleared;

  always_comb
  begin
    state_next      = state_reg;
    state_next.mem_we   = 1'b0;
    state_next.wd_clear = 1'b0;
    sum_w           = 12'h000;
    fix_lo          = 5'h00;
    fix_hi          = 9'h000;
    fix_lo_c        = 1'b0;
    mem_bit_cleared = I_MEM_RDATA;
    mem_bit_cleared[I_BIT_SEL] = 1'b0;
    if (state_reg.asleep)
    begin
      // Sleep holds all registers but expiry, which an expiry still sets, and the mem_we/wd_clear strobes, which drop; only a wake restarts execution.
      if (I_WAKE)
      begin
        state_next.asleep = 1'b0;
      end
    end
    else if (I_EXEC)
    begin
      state_next.pc = state_reg.pc + 12'h001;
      state_next.mem_waddr = I_MEM_ADDR;
      unique case (I_OPCODE)
        iex_pkg::OP_AND_IMM:
        begin
          state_next.acc  = state_reg.acc & I_IMMEDIATE;
          state_next.zero = (state_next.acc == 8'h00);
        end
        iex_pkg::OP_AND_MEM:
        begin
          state_next.acc  = state_reg.acc & I_MEM_RDATA;
          state_next.zero = (state_next.acc == 8'h00);
        end
        iex_pkg::OP_AND_TO_MEM:
        begin
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = state_reg.acc & I_MEM_RDATA;
          state_next.zero      = (state_next.mem_wdata == 8'h00);
        end
        iex_pkg::OP_CALL:
        begin
          state_next.sp = state_reg.sp + 3'h1;
          state_next.pc = I_TARGET;
        end
        iex_pkg::OP_DEC, iex_pkg::OP_DEC_A:
        begin
          if (I_OPCODE == iex_pkg::OP_DEC)
          begin
            state_next.mem_we    = 1'b1;
            state_next.mem_wdata = I_MEM_RDATA - 8'h01;
          end
          else
          begin
            state_next.acc = I_MEM_RDATA - 8'h01;
          end
          state_next.zero = (I_MEM_RDATA == 8'h01);
        end
        iex_pkg::OP_INC:
        begin
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = I_MEM_RDATA + 8'h01;
          state_next.zero      = (I_MEM_RDATA == 8'hFF);
        end
        iex_pkg::OP_INC_A:
        begin
          state_next.acc  = I_MEM_RDATA + 8'h01;
          state_next.zero = (I_MEM_RDATA == 8'hFF);
        end
        iex_pkg::OP_SLEEP:
        begin
          // Arithmetic flags, memory and accumulator are simply not touched here.
          state_next.asleep   = 1'b1;
          state_next.wd_clear = 1'b1;
          state_next.pdown    = 1'b1;
          state_next.expiry   = 1'b0;
        end
        iex_pkg::OP_BRANCH:
        begin
          state_next.pc = I_TARGET;
        end
        iex_pkg::OP_COPY_A:
        begin
          state_next.acc = I_MEM_RDATA;
        end
        iex_pkg::OP_COPY_M:
        begin
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = state_reg.acc;
        end
        iex_pkg::OP_COPY_IMM:
        begin
          state_next.acc = I_IMMEDIATE;
        end
        iex_pkg::OP_PRECLR1, iex_pkg::OP_PRECLR2:
        begin
          // A paired clear needs the partner seen since the last paired clear.
          if ((PRECLEAR_PAIRED == 0) ||
              ((I_OPCODE == iex_pkg::OP_PRECLR1) ? state_reg.pre2_seen : state_reg.pre1_seen))
          begin
            state_next.wd_clear  = 1'b1;
            state_next.expiry    = 1'b0;
            state_next.pdown     = 1'b0;
            state_next.pre1_seen = 1'b0;
            state_next.pre2_seen = 1'b0;
          end
          else if (I_OPCODE == iex_pkg::OP_PRECLR1)
          begin
            state_next.pre1_seen = 1'b1;
          end
          else
          begin
            state_next.pre2_seen = 1'b1;
          end
        end
        iex_pkg::OP_ADC, iex_pkg::OP_ADC_TO_MEM, iex_pkg::OP_ADD_MEM, iex_pkg::OP_ADD_IMM,
        iex_pkg::OP_ADD_TO_MEM:
        begin
          if (I_OPCODE == iex_pkg::OP_ADD_IMM)
          begin
            sum_w = iex_add(state_reg.acc, I_IMMEDIATE, 1'b0);
          end
          else
          begin
            sum_w = iex_add(state_reg.acc, I_MEM_RDATA,
                            ((I_OPCODE == iex_pkg::OP_ADC) ||
                             (I_OPCODE == iex_pkg::OP_ADC_TO_MEM)) & state_reg.carry);
          end
          if ((I_OPCODE == iex_pkg::OP_ADC_TO_MEM) || (I_OPCODE == iex_pkg::OP_ADD_TO_MEM))
          begin
            state_next.mem_we    = 1'b1;
            state_next.mem_wdata = sum_w[8:1];
          end
          else
          begin
            state_next.acc = sum_w[8:1];
          end
          state_next.ovf   = sum_w[11];
          state_next.half  = sum_w[10];
          state_next.carry = sum_w[9];
          state_next.zero  = (sum_w[8:1] == 8'h00);
        end
        iex_pkg::OP_FIXUP:
        begin
          if ((state_reg.acc[3:0] > iex_pkg::BCD_MAX) || state_reg.half)
          begin
            fix_lo = {1'b0, state_reg.acc[3:0]} + {1'b0, iex_pkg::BCD_FIX[3:0]};
          end
          else
          begin
            fix_lo = {1'b0, state_reg.acc[3:0]};
          end
          fix_lo_c = fix_lo[4];
          fix_hi = {5'h00, state_reg.acc[7:4]} + {8'h00, fix_lo_c};
          if ((fix_hi[4:0] > {1'b0, iex_pkg::BCD_MAX}) || state_reg.carry)
          begin
            fix_hi = fix_hi + {5'h00, iex_pkg::BCD_FIX[3:0]};
          end
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = {fix_hi[3:0], fix_lo[3:0]};
          state_next.carry     = (fix_hi[8:4] != 5'h00) || state_reg.carry;
        end
        iex_pkg::OP_INVERT:
        begin
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = ~I_MEM_RDATA;
          state_next.zero      = (I_MEM_RDATA == 8'hFF);
        end
        iex_pkg::OP_INVERT_A:
        begin
          state_next.acc  = ~I_MEM_RDATA;
          state_next.zero = (I_MEM_RDATA == 8'hFF);
        end
        iex_pkg::OP_WD_CLEAR:
        begin
          state_next.wd_clear = 1'b1;
          state_next.expiry   = 1'b0;
          state_next.pdown    = 1'b0;
        end
        iex_pkg::OP_MEM_CLEAR:
        begin
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = 8'h00;
        end
        iex_pkg::OP_BIT_CLEAR:
        begin
          state_next.mem_we    = 1'b1;
          state_next.mem_wdata = mem_bit_cleared;
        end
        default:
        begin
          state_next.pc = state_reg.pc + 12'h001;
        end
      endcase
    end
    // An expiry that meets a clearing instruction in one cycle still sets the bit.
    // A timeout is then never lost, at the price of one more clear by software.
    if (I_WD_EXPIRE)
    begin
      state_next.expiry = 1'b1;
    end
    // The clock gate has its own flop so that the pin carries no decode glitch.
    state_next.run = !state_next.asleep;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      state_reg <= '{pc: iex_pkg::PC_RESET, acc: iex_pkg::ACC_RESET, mem_we: 1'b0,
                     mem_waddr: 8'h00, mem_wdata: 8'h00, zero: 1'b0, carry: 1'b0,
                     half: 1'b0, ovf: 1'b0, expiry: 1'b0, pdown: 1'b0, wd_clear: 1'b0,
                     asleep: 1'b0, run: 1'b1, pre1_seen: 1'b0, pre2_seen: 1'b0,
                     sp: iex_pkg::SP_RESET};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // The return stack wraps after its depth; an overflowing call overwrites the oldest entry.
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESET && I_EXEC && !state_reg.asleep && (I_OPCODE == iex_pkg::OP_CALL))
    begin
      stack_mem[state_reg.sp] <= state_reg.pc + 12'h001;
    end
  end

  assign O_PC                     = state_reg.pc;
  assign O_WORK_REG               = state_reg.acc;
  assign O_MEM_WE                 = state_reg.mem_we;
  assign O_MEM_WADDR              = state_reg.mem_waddr;
  assign O_MEM_WDATA              = state_reg.mem_wdata;
  assign O_ZERO                   = state_reg.zero;
  assign O_CARRY                  = state_reg.carry;
  assign O_HALF_SPILL_BIT         = state_reg.half;
  assign O_SIGNED_RANGE_FAULT_BIT = state_reg.ovf;
  assign O_WATCHDOG_EXPIRY_BIT    = state_reg.expiry;
  assign O_POWERDOWN_BIT          = state_reg.pdown;
  assign O_WATCHDOG_CLEAR         = state_reg.wd_clear;
  assign O_CLOCK_RUN              = state_reg.run;
  assign O_STACK_PTR              = state_reg.sp;

endmodule : iex_core
`default_nettype wire

/* include/iex_pkg.sv */
// Package with opcodes, widths and reset values of the instruction execute core.
`default_nettype none
package iex_pkg;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PC_W    = 12;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned STACK_D = 8;
  localparam int unsigned SP_W    = 3;
  localparam int unsigned OP_W    = 5;
  localparam logic [PC_W-1:0]   PC_RESET  = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [SP_W-1:0]   SP_RESET  = 3'h0;
  localparam logic [DATA_W-1:0] BCD_FIX   = 8'h06;
  localparam logic [3:0]        BCD_MAX   = 4'h9;
  // Opcode encoding of the execute request port.
  localparam logic [OP_W-1:0] OP_NOP        = 5'h00;
  localparam logic [OP_W-1:0] OP_AND_IMM    = 5'h01;
  localparam logic [OP_W-1:0] OP_CALL       = 5'h02;
  localparam logic [OP_W-1:0] OP_DEC        = 5'h03;
  localparam logic [OP_W-1:0] OP_DEC_A      = 5'h04;
  localparam logic [OP_W-1:0] OP_INC        = 5'h05;
  localparam logic [OP_W-1:0] OP_INC_A      = 5'h06;
  localparam logic [OP_W-1:0] OP_SLEEP      = 5'h07;
  localparam logic [OP_W-1:0] OP_BRANCH     = 5'h08;
  localparam logic [OP_W-1:0] OP_COPY_A     = 5'h09;
  localparam logic [OP_W-1:0] OP_PRECLR1    = 5'h0A;
  localparam logic [OP_W-1:0] OP_PRECLR2    = 5'h0B;
  localparam logic [OP_W-1:0] OP_ADC        = 5'h0C;
  localparam logic [OP_W-1:0] OP_ADC_TO_MEM = 5'h0D;
  localparam logic [OP_W-1:0] OP_ADD_MEM    = 5'h0E;
  localparam logic [OP_W-1:0] OP_ADD_IMM    = 5'h0F;
  localparam logic [OP_W-1:0] OP_ADD_TO_MEM = 5'h10;
  localparam logic [OP_W-1:0] OP_FIXUP      = 5'h11;
  localparam logic [OP_W-1:0] OP_INVERT     = 5'h12;
  localparam logic [OP_W-1:0] OP_INVERT_A   = 5'h13;
  localparam logic [OP_W-1:0] OP_WD_CLEAR   = 5'h14;
  localparam logic [OP_W-1:0] OP_MEM_CLEAR  = 5'h15;
  localparam logic [OP_W-1:0] OP_BIT_CLEAR  = 5'h16;
  localparam logic [OP_W-1:0] OP_AND_MEM    = 5'h17;
  localparam logic [OP_W-1:0] OP_AND_TO_MEM = 5'h18;
  localparam logic [OP_W-1:0] OP_COPY_M     = 5'h19;
  localparam logic [OP_W-1:0] OP_COPY_IMM   = 5'h1A;
endpackage : iex_pkg
`default_nettype wire

/* verification/iex_core_props.sv */
// Concurrent checks on the ports of the instruction execute core.
`default_nettype none
module iex_core_props (
  input wire logic                        I_CLOCK,
  input wire logic                        I_RESET,
  input wire logic                        I_EXEC,
  input wire logic [iex_pkg::OP_W-1:0]    I_OPCODE,
  input wire logic [iex_pkg::ADDR_W-1:0]  I_MEM_ADDR,
  input wire logic [iex_pkg::DATA_W-1:0]  I_MEM_RDATA,
  input wire logic [iex_pkg::DATA_W-1:0]  I_IMMEDIATE,
  input wire logic [iex_pkg::PC_W-1:0]    I_TARGET,
  input wire logic                        I_WAKE,
  input wire logic                        I_WD_EXPIRE,
  input wire logic [iex_pkg::PC_W-1:0]    O_PC,
  input wire logic [iex_pkg::DATA_W-1:0]  O_WORK_REG,
  input wire logic                        O_MEM_WE,
  input wire logic [iex_pkg::ADDR_W-1:0]  O_MEM_WADDR,
  input wire logic [iex_pkg::DATA_W-1:0]  O_MEM_WDATA,
  input wire logic                        O_ZERO,
  input wire logic                        O_CARRY,
  input wire logic                        O_WATCHDOG_EXPIRY_BIT,
  input wire logic                        O_POWERDOWN_BIT,
  input wire logic                        O_WATCHDOG_CLEAR,
  input wire logic                        O_CLOCK_RUN,
  input wire logic [iex_pkg::SP_W-1:0]    O_STACK_PTR
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  // A request only counts while the core is awake.
  sequence s_go(logic [4:0] op);
    I_EXEC && O_CLOCK_RUN && I_OPCODE == op;
  endsequence
  property p_and_imm;
    s_go(iex_pkg::OP_AND_IMM) |=> O_WORK_REG == ($past(O_WORK_REG) & $past(I_IMMEDIATE))
      && O_ZERO == (O_WORK_REG == 8'h00) && $stable(O_CARRY);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
  property p_call;
    s_go(iex_pkg::OP_CALL) |=> O_PC == $past(I_TARGET) && $stable(O_ZERO)
      && O_STACK_PTR == $past(O_STACK_PTR) + 3'h1 && $stable(O_CARRY);
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_dec;
    s_go(iex_pkg::OP_DEC) |=> O_MEM_WE && O_MEM_WDATA == $past(I_MEM_RDATA) - 8'h01
      && O_ZERO == (O_MEM_WDATA == 8'h00) && $stable(O_CARRY);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_inc;
    s_go(iex_pkg::OP_INC) |=> O_MEM_WE && O_MEM_WDATA == $past(I_MEM_RDATA) + 8'h01
      && O_ZERO == (O_MEM_WDATA == 8'h00);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_step_up_to_work_register;
    s_go(iex_pkg::OP_INC_A) |=> !O_MEM_WE && O_WORK_REG == $past(I_MEM_RDATA) + 8'h01;
  endproperty
  a_step_up_to_work_register: assert property (p_step_up_to_work_register) else $error("increment to register wrong");
  property p_sleep;
    s_go(iex_pkg::OP_SLEEP) |=> !O_CLOCK_RUN && O_POWERDOWN_BIT
      && (O_WATCHDOG_EXPIRY_BIT == $past(I_WD_EXPIRE))
      && O_WATCHDOG_CLEAR && O_PC == $past(O_PC) + 12'h001;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_held;
    !O_CLOCK_RUN && !I_WAKE |=> $stable(O_PC) && $stable(O_WORK_REG) && !O_MEM_WE;
  endproperty
  a_held: assert property (p_held) else $error("state moved while asleep");
  property p_branch;
    s_go(iex_pkg::OP_BRANCH) |=> O_PC == $past(I_TARGET) && $stable({O_ZERO, O_CARRY});
  endproperty
  a_branch: assert property (p_branch) else $error("branch wrong");
  property p_copy;
    s_go(iex_pkg::OP_COPY_A) |=> O_WORK_REG == $past(I_MEM_RDATA) && $stable(O_ZERO);
  endproperty
  a_copy: assert property (p_copy) else $error("copy wrong");
  property p_we;
    O_MEM_WE |-> $past(I_EXEC) && O_MEM_WADDR == $past(I_MEM_ADDR);
  endproperty
  a_we: assert property (p_we) else $error("stray memory write");
endmodule : iex_core_props
`default_nettype wire

/* verification/iex_core_tb.sv */
// Self-checking bench driving directed and random instructions into the execute core.
`default_nettype none
bind iex_core iex_core_props iex_core_props_i (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
  .I_EXEC(I_EXEC), .I_OPCODE(I_OPCODE), .I_MEM_ADDR(I_MEM_ADDR), .I_MEM_RDATA(I_MEM_RDATA),
  .I_IMMEDIATE(I_IMMEDIATE), .I_TARGET(I_TARGET), .I_WAKE(I_WAKE),
  .I_WD_EXPIRE(I_WD_EXPIRE), .O_PC(O_PC),
  .O_WORK_REG(O_WORK_REG), .O_MEM_WE(O_MEM_WE), .O_MEM_WADDR(O_MEM_WADDR),
  .O_MEM_WDATA(O_MEM_WDATA), .O_ZERO(O_ZERO), .O_CARRY(O_CARRY),
  .O_WATCHDOG_EXPIRY_BIT(O_WATCHDOG_EXPIRY_BIT), .O_POWERDOWN_BIT(O_POWERDOWN_BIT),
  .O_WATCHDOG_CLEAR(O_WATCHDOG_CLEAR), .O_CLOCK_RUN(O_CLOCK_RUN), .O_STACK_PTR(O_STACK_PTR));
module iex_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, ex = 1'b0, wake = 1'b0, wdx = 1'b0;
  logic [4:0]  op = 5'h00;
  logic [7:0]  addr = 8'h00, imm = 8'h00, wreg, wa, wd, m_acc = 8'h00;
  logic [11:0] tgt = 12'h000, pc, m_pc = 12'h000;
  logic [2:0]  bsel = 3'h0, sp, m_sp = 3'h0;
  logic        we, z, c, h, v, to, pd, wdc, run, m_run = 1'b1;
  logic        m_z = 1'b0, m_c = 1'b0, m_h = 1'b0, m_v = 1'b0, m_to = 1'b0, m_pd = 1'b0;
  logic        s1 = 1'b0, s2 = 1'b0;
  logic [7:0]  mem [256];
  int          num_errors = 0;
  int          check_count = 0;
  wire logic [7:0] rdata = mem[addr];
  iex_core iex_core_i (
    .I_CLOCK(clk), .I_RESET(rst), .I_EXEC(ex), .I_OPCODE(op), .I_MEM_ADDR(addr),
    .I_MEM_RDATA(rdata), .I_IMMEDIATE(imm), .I_TARGET(tgt), .I_BIT_SEL(bsel),
    .I_WAKE(wake), .I_WD_EXPIRE(wdx), .O_PC(pc), .O_WORK_REG(wreg), .O_MEM_WE(we),
    .O_MEM_WADDR(wa), .O_MEM_WDATA(wd), .O_ZERO(z), .O_CARRY(c), .O_HALF_SPILL_BIT(h),
    .O_SIGNED_RANGE_FAULT_BIT(v), .O_WATCHDOG_EXPIRY_BIT(to), .O_POWERDOWN_BIT(pd),
    .O_WATCHDOG_CLEAR(wdc), .O_CLOCK_RUN(run), .O_STACK_PTR(sp)
  );
  always #25 clk = ~clk;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  // Quiet cycles with no request driven; the PC and work register must hold.
  task automatic idle(input int n);
    ex <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk({pc, wreg}, {m_pc, m_acc});
  endtask : idle
  // Pulses the wake line (w=1) or the watchdog expiry line (w=0) for one cycle.
  task automatic pin(input logic w);
    ex <= 1'b0;
    wake <= w;
    wdx <= !w;
    @(posedge clk);
    #1;
    wake <= 1'b0;
    wdx <= 1'b0;
    if (w)
      m_run = 1'b1;
    else
      m_to = 1'b1;
    chk({to, pd, run}, {m_to, m_pd, m_run});
  endtask : pin
  // Issues one instruction; ad[8] set picks a random operand address.
  task automatic go(input logic [4:0] o, input logic [8:0] ad);
    logic [7:0]  a, x, r, y, res;
    logic [11:0] t;
    logic [2:0]  b;
    logic [8:0]  s;
    logic [4:0]  l, u;
    logic        wr, cl, ci;
    a = ad[8] ? 8'($urandom) : ad[7:0];
    x = 8'($urandom);
    t = 12'($urandom);
    b = 3'($urandom);
    r = mem[a];
    res = r;
    cl = 1'b0;
    op <= o;
    addr <= a;
    imm <= x;
    tgt <= t;
    bsel <= b;
    ex <= 1'b1;
    wr = m_run && (o inside {iex_pkg::OP_AND_TO_MEM, iex_pkg::OP_DEC, iex_pkg::OP_INC,
      iex_pkg::OP_INVERT, iex_pkg::OP_COPY_M, iex_pkg::OP_MEM_CLEAR, iex_pkg::OP_BIT_CLEAR,
      iex_pkg::OP_ADC_TO_MEM, iex_pkg::OP_ADD_TO_MEM, iex_pkg::OP_FIXUP});
    if (m_run)
    begin
      m_pc = m_pc + 12'h001;
      case (o)
        iex_pkg::OP_AND_IMM, iex_pkg::OP_AND_MEM, iex_pkg::OP_AND_TO_MEM:
          res = m_acc & ((o == iex_pkg::OP_AND_IMM) ? x : r);
        iex_pkg::OP_CALL:
        begin
          m_sp = m_sp + 3'h1;
          m_pc = t;
        end
        iex_pkg::OP_BRANCH: m_pc = t;
        iex_pkg::OP_DEC, iex_pkg::OP_DEC_A: res = r - 8'h01;
        iex_pkg::OP_INC, iex_pkg::OP_INC_A: res = r + 8'h01;
        iex_pkg::OP_INVERT, iex_pkg::OP_INVERT_A: res = ~r;
        iex_pkg::OP_COPY_M: res = m_acc;
        iex_pkg::OP_COPY_IMM: res = x;
        iex_pkg::OP_MEM_CLEAR: res = 8'h00;
        iex_pkg::OP_BIT_CLEAR: res[b] = 1'b0;
        iex_pkg::OP_SLEEP:
        begin
          m_run = 1'b0;
          cl = 1'b1;
        end
        iex_pkg::OP_WD_CLEAR:
        begin
          cl = 1'b1;
          s1 = 1'b0;
          s2 = 1'b0;
        end
        iex_pkg::OP_PRECLR1:
        begin
          cl = s2;
          s1 = !s2;
          s2 = 1'b0;
        end
        iex_pkg::OP_PRECLR2:
        begin
          cl = s1;
          s2 = !s1;
          s1 = 1'b0;
        end
        iex_pkg::OP_FIXUP:
        begin
          l = {1'b0, m_acc[3:0]} + ((m_acc[3:0] > 4'h9 || m_h) ? 5'h06 : 5'h00);
          u = {1'b0, m_acc[7:4]} + {4'h0, l[4]};
          if (u > 5'h09 || m_c)
            u = u + 5'h06;
          m_c = m_c | u[4];
          res = {u[3:0], l[3:0]};
        end
        iex_pkg::OP_ADC, iex_pkg::OP_ADC_TO_MEM, iex_pkg::OP_ADD_MEM, iex_pkg::OP_ADD_IMM,
        iex_pkg::OP_ADD_TO_MEM:
        begin
          y = (o == iex_pkg::OP_ADD_IMM) ? x : r;
          ci = (o == iex_pkg::OP_ADC || o == iex_pkg::OP_ADC_TO_MEM) && m_c;
          s = {1'b0, m_acc} + {1'b0, y} + {8'h00, ci};
          l = {1'b0, m_acc[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
          m_c = s[8];
          m_h = l[4];
          m_v = (m_acc[7] == y[7]) && (s[7] != y[7]);
          res = s[7:0];
        end
        default: ;
      endcase
      if (o inside {iex_pkg::OP_AND_IMM, iex_pkg::OP_AND_MEM, iex_pkg::OP_DEC_A,
        iex_pkg::OP_INC_A, iex_pkg::OP_INVERT_A, iex_pkg::OP_COPY_A, iex_pkg::OP_COPY_IMM,
        iex_pkg::OP_ADC, iex_pkg::OP_ADD_MEM, iex_pkg::OP_ADD_IMM})
        m_acc = res;
      if (o inside {iex_pkg::OP_AND_IMM, iex_pkg::OP_AND_MEM, iex_pkg::OP_AND_TO_MEM,
        iex_pkg::OP_DEC, iex_pkg::OP_DEC_A, iex_pkg::OP_INC, iex_pkg::OP_INC_A,
        iex_pkg::OP_INVERT, iex_pkg::OP_INVERT_A, iex_pkg::OP_ADC, iex_pkg::OP_ADC_TO_MEM,
        iex_pkg::OP_ADD_MEM, iex_pkg::OP_ADD_IMM, iex_pkg::OP_ADD_TO_MEM})
        m_z = (res == 8'h00);
      if (cl)
      begin
        m_to = 1'b0;
        m_pd = (o == iex_pkg::OP_SLEEP);
      end
    end
    @(posedge clk);
    #1;
    chk({pc, wreg}, {m_pc, m_acc});
    chk({z, c, h, v, to, pd, run, sp}, {m_z, m_c, m_h, m_v, m_to, m_pd, m_run, m_sp});
    chk({we, wdc}, {wr, cl});
    if (wr)
    begin
      chk({wa, wd}, {a, res});
      mem[a] = res;
    end
  endtask : go
  initial
  begin
    logic [4:0] o;
    void'($urandom(32'h423b));
    foreach (mem[i]) mem[i] = 8'(i);
    repeat (6) @(posedge clk);
    #1;
    rst <= 1'b0;
    pin(1'b0);
    go(iex_pkg::OP_PRECLR1, 9'h100);
    go(iex_pkg::OP_INC, 9'h0FF);
    go(iex_pkg::OP_DEC, 9'h001);
    go(iex_pkg::OP_PRECLR1, 9'h100);
    go(iex_pkg::OP_PRECLR2, 9'h100);
    go(iex_pkg::OP_SLEEP, 9'h100);
    go(iex_pkg::OP_INC, 9'h100);
    idle(3);
    pin(1'b1);
    go(iex_pkg::OP_PRECLR2, 9'h100);
    go(iex_pkg::OP_PRECLR1, 9'h100);
    pin(1'b0);
    go(iex_pkg::OP_WD_CLEAR, 9'h100);
    go(iex_pkg::OP_INVERT, 9'h0FF);
    go(iex_pkg::OP_INC_A, 9'h0FF);
    for (int n = 0; n < 400; n++)
    begin
      o = 5'($urandom_range(26));
      if (o inside {iex_pkg::OP_SLEEP, iex_pkg::OP_PRECLR1, iex_pkg::OP_PRECLR2,
        iex_pkg::OP_WD_CLEAR})
        o = 5'h1F;
      go(o, 9'h100);
      if (n % 4 == 3)
        idle(1);
    end
    idle(1);
    summarize();
  end
endmodule : iex_core_tb
`default_nettype wire
